// >>> rtl/pin_remap_lock.sv
// Notes on behaviour
// - Four internal virtual pins act like remappable pins, without package pins.
// - A peripheral output on a virtual pin feeds inputs selecting that pin.
// - Map register writes while locked complete normally but change nothing.
// - Lock is bit 6 of oscillator control; one blocks map writes.
// - Lock holds its value until software changes it again or a device reset clears it.
// - Map registers are compared with shadows; mismatch requests a reset.
// - One-way mode refuses clearing the lock once set; unlock does nothing.
// - In one-way mode only device reset clears the lock.
// - One-way bit reads set when unprogrammed; cleared allows unlimited sessions.
// - Output map 6: bits 13-8 pin 13, bits 5-0 pin 12, reset zero.
// - Output map 7: bits 13-8 pin 15, bits 5-0 pin 14, reset zero.
// - Bits 15-14 and 7-6 of output maps ignore writes, read zero.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module pin_remap_lock #(
    parameter int SEL_W    = pin_remap_pkg::SEL_W,
    parameter int NUM_VIRT = pin_remap_pkg::NUM_VIRT
) (
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_HSEL,
    input  wire logic [31:0]                   I_HADDR,
    input  wire logic [1:0]                    I_HTRANS,
    input  wire logic                          I_HWRITE,
    input  wire logic [2:0]                    I_HSIZE,
    input  wire logic [31:0]                   I_HWDATA,
    input  wire logic                          I_HREADY,
    output logic      [31:0]                   O_HRDATA,
    output logic                               O_HREADYOUT,
    output logic                               O_HRESP,
    input  wire logic                          I_ONE_WAY_CFG_N,
    input  wire logic [(1<<SEL_W)-1:0]         I_PERIPH_OUT,
    output logic      [3:0]                    O_PIN_OUT,
    output logic      [NUM_VIRT-1:0]           O_VIRT_PIN,
    output logic      [4*SEL_W-1:0]            O_IN_SELECT,
    output logic                               O_MISMATCH_RESET,
    output logic                               O_IRQ
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                          pend_wr;
        logic [7:0]                    pend_addr;
        logic [15:0]                   map6;
        logic [15:0]                   map7;
        logic [15:0]                   inmap0;
        logic [15:0]                   inmap1;
        logic [15:0]                   sh6;
        logic [15:0]                   sh7;
        logic [15:0]                   shi0;
        logic [15:0]                   shi1;
        logic                          lock;
        pin_remap_pkg::key_state_e     key;
        logic [pin_remap_pkg::IRQ_W-1:0] stat;
        logic [pin_remap_pkg::IRQ_W-1:0] en;
        logic                          mism;
        logic [31:0]                   rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic                              wr_now;
    logic [15:0]                       wd;
    logic                              map_hit;
    logic                              locked_eff;
    logic [pin_remap_pkg::IRQ_W-1:0]   ev;
    logic [15:0]                       in_mask;
    logic                              hit_osc;
    logic                              hit_map6;
    logic                              hit_map7;
    logic                              hit_in0;
    logic                              hit_in1;
    logic                              hit_en;
    logic                              hit_clr;
    logic                              diff6;
    logic                              diff7;
    logic                              diffi0;
    logic                              diffi1;

    // Unprogrammed fuse reads one, so one-way is active by default
    logic                              one_way;
    assign one_way = I_ONE_WAY_CFG_N;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Only the low address byte is decoded, so the registers alias upward
    assign wr_now   = st_r.pend_wr;
    assign wd       = I_HWDATA[15:0];
    assign in_mask  = 16'({2'b00, {SEL_W{1'b1}}, 2'b00, {SEL_W{1'b1}}});
    assign hit_osc  = (st_r.pend_addr == pin_remap_pkg::OSC_CTRL_OFF);
    assign hit_map6 = (st_r.pend_addr == pin_remap_pkg::OUT_MAP6_OFF);
    assign hit_map7 = (st_r.pend_addr == pin_remap_pkg::OUT_MAP7_OFF);
    assign hit_in0  = (st_r.pend_addr == pin_remap_pkg::IN_MAP0_OFF);
    assign hit_in1  = (st_r.pend_addr == pin_remap_pkg::IN_MAP1_OFF);
    assign hit_en   = (st_r.pend_addr == pin_remap_pkg::IRQ_EN_OFF);
    assign hit_clr  = (st_r.pend_addr == pin_remap_pkg::IRQ_CLR_OFF);
    assign map_hit  = hit_map6 || hit_map7 || hit_in0 || hit_in1;
    assign locked_eff = st_r.lock;

    // ----------------------------------------------------------------
    // Shadow compare
    // ----------------------------------------------------------------
    // Shadows load the same masked value as the map, so a difference can
    // only come from a disturbed cell, never from software
    assign diff6  = (st_r.map6 != st_r.sh6);
    assign diff7  = (st_r.map7 != st_r.sh7);
    assign diffi0 = (st_r.inmap0 != st_r.shi0);
    assign diffi1 = (st_r.inmap1 != st_r.shi1);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        ev     = '0;
        // ----------------------------------------------------------------
        // Bus capture
        // ----------------------------------------------------------------
        // Address phase capture; zero wait states so every phase is taken
        st_nxt.pend_wr   = I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
        st_nxt.pend_addr = I_HADDR[7:0];

        // ----------------------------------------------------------------
        // Key sequence and map writes
        // ----------------------------------------------------------------
        if (wr_now)
        begin
            if (hit_osc)
            begin
                unique case (st_r.key)
                    pin_remap_pkg::KEY_IDLE:
                    begin
                        if (wd[7:0] == pin_remap_pkg::KEY_FIRST)
                        begin
                            st_nxt.key = pin_remap_pkg::KEY_ONE;
                        end
                    end
                    pin_remap_pkg::KEY_ONE:
                    begin
                        if (wd[7:0] == pin_remap_pkg::KEY_SECOND)
                        begin
                            st_nxt.key = pin_remap_pkg::KEY_TWO;
                        end
                        else
                        begin
                            st_nxt.key = pin_remap_pkg::KEY_IDLE;
                            ev[pin_remap_pkg::EV_SEQ_ABORT] = 1'b1;
                        end
                    end
                    pin_remap_pkg::KEY_TWO:
                    begin
                        // Only a clear is refused in one-way mode; setting again is harmless
                        st_nxt.key = pin_remap_pkg::KEY_IDLE;
                        if (one_way && st_r.lock && !wd[pin_remap_pkg::LOCK_BIT])
                        begin
                            ev[pin_remap_pkg::EV_REFUSED] = 1'b1;
                        end
                        else
                        begin
                            st_nxt.lock = wd[pin_remap_pkg::LOCK_BIT];
                        end
                    end
                    default:
                    begin
                        st_nxt.key = pin_remap_pkg::KEY_IDLE;
                    end
                endcase
            end
            else
            begin
                if (st_r.key != pin_remap_pkg::KEY_IDLE)
                begin
                    st_nxt.key = pin_remap_pkg::KEY_IDLE;
                    ev[pin_remap_pkg::EV_SEQ_ABORT] = 1'b1;
                end
                // A refused write still ends OKAY, so software sees no fault
                if (map_hit && locked_eff)
                begin
                    ev[pin_remap_pkg::EV_REFUSED] = 1'b1;
                end
                else if (map_hit)
                begin
                    // Shadows follow every legal write so only disturbances differ
                    unique case (st_r.pend_addr)
                        pin_remap_pkg::OUT_MAP6_OFF:
                        begin
                            st_nxt.map6 = wd & pin_remap_pkg::OUT_MAP_MASK;
                            st_nxt.sh6  = wd & pin_remap_pkg::OUT_MAP_MASK;
                        end
                        pin_remap_pkg::OUT_MAP7_OFF:
                        begin
                            st_nxt.map7 = wd & pin_remap_pkg::OUT_MAP_MASK;
                            st_nxt.sh7  = wd & pin_remap_pkg::OUT_MAP_MASK;
                        end
                        pin_remap_pkg::IN_MAP0_OFF:
                        begin
                            st_nxt.inmap0 = wd & in_mask;
                            st_nxt.shi0   = wd & in_mask;
                        end
                        default:
                        begin
                            st_nxt.inmap1 = wd & in_mask;
                            st_nxt.shi1   = wd & in_mask;
                        end
                    endcase
                end
                if (hit_en)
                begin
                    st_nxt.en = wd[pin_remap_pkg::IRQ_W-1:0];
                end
            end
        end

        // ----------------------------------------------------------------
        // Shadow monitor
        // ----------------------------------------------------------------
        st_nxt.mism = diff6 || diff7 || diffi0 || diffi1;
        ev[pin_remap_pkg::EV_MISMATCH] = st_nxt.mism;

        // ----------------------------------------------------------------
        // Status flags
        // ----------------------------------------------------------------
        // Set wins over clear, so an event in the clearing cycle is not lost
        if (wr_now && hit_clr)
        begin
            st_nxt.stat = st_r.stat & ~wd[pin_remap_pkg::IRQ_W-1:0];
        end
        st_nxt.stat = st_nxt.stat | ev;

        // ----------------------------------------------------------------
        // Read data
        // ----------------------------------------------------------------
        // Registered at the address phase from next-state values, so a read
        // right behind a write already returns the new contents
        st_nxt.rdata = 32'h0000_0000;
        if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE)
        begin
            unique case (I_HADDR[7:0])
                pin_remap_pkg::OSC_CTRL_OFF:
                begin
                    st_nxt.rdata[pin_remap_pkg::LOCK_BIT] = st_nxt.lock;
                end
                pin_remap_pkg::OUT_MAP6_OFF:
                begin
                    st_nxt.rdata[15:0] = st_nxt.map6;
                end
                pin_remap_pkg::OUT_MAP7_OFF:
                begin
                    st_nxt.rdata[15:0] = st_nxt.map7;
                end
                pin_remap_pkg::IN_MAP0_OFF:
                begin
                    st_nxt.rdata[15:0] = st_nxt.inmap0;
                end
                pin_remap_pkg::IN_MAP1_OFF:
                begin
                    st_nxt.rdata[15:0] = st_nxt.inmap1;
                end
                pin_remap_pkg::IRQ_STAT_OFF:
                begin
                    st_nxt.rdata[pin_remap_pkg::IRQ_W-1:0] = st_nxt.stat;
                end
                pin_remap_pkg::IRQ_EN_OFF:
                begin
                    st_nxt.rdata[pin_remap_pkg::IRQ_W-1:0] = st_nxt.en;
                end
                pin_remap_pkg::LOCK_CFG_OFF:
                begin
                    st_nxt.rdata[0] = I_ONE_WAY_CFG_N;
                end
                default:
                begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            st_r      <= '0;
            st_r.lock <= pin_remap_pkg::LOCK_RESET;
            st_r.key  <= pin_remap_pkg::KEY_IDLE;
            st_r.map6 <= pin_remap_pkg::MAP_RESET;
            st_r.sh6  <= pin_remap_pkg::MAP_RESET;
            st_r.map7 <= pin_remap_pkg::MAP_RESET;
            st_r.sh7  <= pin_remap_pkg::MAP_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    // Selectors index peripheral outputs only, never virtual pins; virtual pins
    // are fed by selections 0..3 of output map 6/7 fields, giving a loop-free path
    logic [SEL_W-1:0] pin_sel [4];
    assign pin_sel[0] = st_r.map6[SEL_W-1:0];
    assign pin_sel[1] = st_r.map6[8+SEL_W-1:8];
    assign pin_sel[2] = st_r.map7[SEL_W-1:0];
    assign pin_sel[3] = st_r.map7[8+SEL_W-1:8];

    generate
        for (genvar g = 0; g < pin_remap_pkg::NUM_PINS; g++)
        begin : g_pin
            assign O_PIN_OUT[g] = I_PERIPH_OUT[pin_sel[g]];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Virtual pins
    // ----------------------------------------------------------------
    // These never reach a pad; peripherals pick them up through O_IN_SELECT
    generate
        for (genvar v = 0; v < NUM_VIRT; v++)
        begin : g_virt
            // Internal pin: peripheral output chosen by the same-indexed field
            assign O_VIRT_PIN[v] = I_PERIPH_OUT[pin_sel[v % 4]];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Mismatch is a level; the reset controller decides how long to act on it
    assign O_IN_SELECT      = {st_r.inmap1[8+SEL_W-1:8], st_r.inmap1[SEL_W-1:0],
                               st_r.inmap0[8+SEL_W-1:8], st_r.inmap0[SEL_W-1:0]};
    assign O_MISMATCH_RESET = st_r.mism;
    assign O_IRQ            = |(st_r.stat & st_r.en);
    assign O_HRDATA         = st_r.rdata;
    assign O_HREADYOUT      = 1'b1;
    assign O_HRESP          = 1'b0;

endmodule : pin_remap_lock

`default_nettype wire

// >>> rtl/pin_remap_pkg.sv
`default_nettype none
package pin_remap_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OSC_CTRL_OFF   = 8'h00;
    localparam logic [7:0] OUT_MAP6_OFF   = 8'h04;
    localparam logic [7:0] OUT_MAP7_OFF   = 8'h08;
    localparam logic [7:0] IN_MAP0_OFF    = 8'h0C;
    localparam logic [7:0] IN_MAP1_OFF    = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFF   = 8'h14;
    localparam logic [7:0] IRQ_EN_OFF     = 8'h18;
    localparam logic [7:0] IRQ_CLR_OFF    = 8'h1C;
    localparam logic [7:0] LOCK_CFG_OFF   = 8'h20;

    // ----------------------------------------------------------------
    // Fields and values
    // ----------------------------------------------------------------
    localparam int         LOCK_BIT       = 6;
    localparam logic [7:0] KEY_FIRST      = 8'h46;
    localparam logic [7:0] KEY_SECOND     = 8'h57;
    localparam logic [15:0] OUT_MAP_MASK  = 16'h3F3F;
    localparam logic [15:0] MAP_RESET     = 16'h0000;
    localparam int         SEL_W          = 6;
    localparam int         NUM_PINS       = 4;
    localparam int         NUM_VIRT       = 4;
    localparam logic       LOCK_RESET     = 1'b0;
    localparam int         IRQ_W          = 3;
    // Event bits
    localparam int         EV_MISMATCH    = 0;
    localparam int         EV_REFUSED     = 1;
    localparam int         EV_SEQ_ABORT   = 2;

    typedef enum logic [2:0]
    {
        KEY_IDLE = 3'b001,
        KEY_ONE  = 3'b010,
        KEY_TWO  = 3'b100
    } key_state_e;

endpackage : pin_remap_pkg
`default_nettype wire

// >>> tb/pin_remap_lock_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pin_remap_lock_checker #(
    parameter int SEL_W    = pin_remap_pkg::SEL_W,
    parameter int NUM_VIRT = pin_remap_pkg::NUM_VIRT
) (
    input wire logic                  I_SYS_CLK,
    input wire logic                  I_RST_N,
    input wire logic                  I_HSEL,
    input wire logic [31:0]           I_HADDR,
    input wire logic [1:0]            I_HTRANS,
    input wire logic                  I_HWRITE,
    input wire logic [2:0]            I_HSIZE,
    input wire logic [31:0]           I_HWDATA,
    input wire logic                  I_HREADY,
    input wire logic [31:0]           O_HRDATA,
    input wire logic                  O_HREADYOUT,
    input wire logic                  O_HRESP,
    input wire logic                  I_ONE_WAY_CFG_N,
    input wire logic [(1<<SEL_W)-1:0] I_PERIPH_OUT,
    input wire logic [3:0]            O_PIN_OUT,
    input wire logic [NUM_VIRT-1:0]   O_VIRT_PIN,
    input wire logic [4*SEL_W-1:0]    O_IN_SELECT,
    input wire logic                  O_MISMATCH_RESET,
    input wire logic                  O_IRQ
);
    // ----------------
    // Helpers
    // ----------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    wire logic ap = I_HSEL && I_HREADY && I_HTRANS[1];
    wire logic wr = ap && I_HWRITE;
    // Only the low byte is decoded here; the bench keeps the upper address bits zero
    wire logic wr_in = wr && (I_HADDR[7:0] == pin_remap_pkg::IN_MAP0_OFF
                           || I_HADDR[7:0] == pin_remap_pkg::IN_MAP1_OFF);
    sequence s_rd(logic [7:0] a);
        ap && !I_HWRITE && I_HADDR[7:0] == a;
    endsequence
    sequence s_map_rd;
        s_rd(pin_remap_pkg::OUT_MAP6_OFF) or s_rd(pin_remap_pkg::OUT_MAP7_OFF);
    endsequence
    // ----------------
    // Assertions
    // ----------------
    a_resp_okay: assert property (O_HRESP == 1'b0)
        else $error("error response seen");
    a_ready_high: assert property (O_HREADYOUT == 1'b1)
        else $error("wait state seen");
    a_rsvd_read_zero: assert property (s_map_rd |=> (O_HRDATA & 32'hFFFF_C0C0) == 32'h0000_0000)
        else $error("reserved map bits read nonzero");
    a_cfg_readback: assert property (s_rd(pin_remap_pkg::LOCK_CFG_OFF)
        |=> O_HRDATA[0] == $past(I_ONE_WAY_CFG_N))
        else $error("config bit reads wrong");
    a_unmapped_zero: assert property (s_rd(8'h24) |=> O_HRDATA == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_no_mismatch: assert property (!O_MISMATCH_RESET)
        else $error("mismatch reset without disturbance");
    a_insel_written: assert property ($changed(O_IN_SELECT) |-> $past(wr_in, 2))
        else $error("input select changed without write");
    a_reset_route: assert property (!$past(I_RST_N) |-> O_PIN_OUT == {4{I_PERIPH_OUT[0]}})
        else $error("pins not on function zero after reset");
    a_map6_route: assert property (s_rd(pin_remap_pkg::OUT_MAP6_OFF)
        |=> O_PIN_OUT[1:0] == {I_PERIPH_OUT[O_HRDATA[8+SEL_W-1:8]], I_PERIPH_OUT[O_HRDATA[SEL_W-1:0]]})
        else $error("pins 12 and 13 do not follow map 6");
    a_map7_route: assert property (s_rd(pin_remap_pkg::OUT_MAP7_OFF)
        |=> O_PIN_OUT[3:2] == {I_PERIPH_OUT[O_HRDATA[8+SEL_W-1:8]], I_PERIPH_OUT[O_HRDATA[SEL_W-1:0]]})
        else $error("pins 14 and 15 do not follow map 7");
    a_virt_route: assert property (s_rd(pin_remap_pkg::OUT_MAP6_OFF)
        |=> O_VIRT_PIN[1:0] == {I_PERIPH_OUT[O_HRDATA[8+SEL_W-1:8]], I_PERIPH_OUT[O_HRDATA[SEL_W-1:0]]})
        else $error("virtual pins do not follow their fields");
    // Events come from writes only here; a status or enable write reaches the interrupt two cycles later
    a_irq_cause: assert property ($rose(O_IRQ) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("interrupt without cause");
endmodule : pin_remap_lock_checker
bind pin_remap_lock pin_remap_lock_checker #(.SEL_W(SEL_W), .NUM_VIRT(NUM_VIRT)) u_pin_remap_lock_checker (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA),
    .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_ONE_WAY_CFG_N(I_ONE_WAY_CFG_N), .I_PERIPH_OUT(I_PERIPH_OUT), .O_PIN_OUT(O_PIN_OUT),
    .O_VIRT_PIN(O_VIRT_PIN), .O_IN_SELECT(O_IN_SELECT), .O_MISMATCH_RESET(O_MISMATCH_RESET), .O_IRQ(O_IRQ));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [7:0] OSC = pin_remap_pkg::OSC_CTRL_OFF;
    localparam logic [7:0] M6  = pin_remap_pkg::OUT_MAP6_OFF;
    localparam logic [7:0] M7  = pin_remap_pkg::OUT_MAP7_OFF;
    localparam logic [7:0] IN0 = pin_remap_pkg::IN_MAP0_OFF;
    localparam logic [7:0] ST  = pin_remap_pkg::IRQ_STAT_OFF;
    localparam logic [7:0] EN  = pin_remap_pkg::IRQ_EN_OFF;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic        clk, rst_n, hwrite, cfg_n;
    logic [63:0] periph;
    wire logic [31:0] hrdata;
    wire logic [23:0] insel;
    wire logic [3:0]  pin_out, virt;
    wire logic        hready, hresp, mism, irq;
    int               fails, checked;

    pin_remap_lock u_pin_remap_lock (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_ONE_WAY_CFG_N(cfg_n),
        .I_PERIPH_OUT(periph), .O_PIN_OUT(pin_out), .O_VIRT_PIN(virt), .O_IN_SELECT(insel),
        .O_MISMATCH_RESET(mism), .O_IRQ(irq));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------
    // Bus tasks
    // ----------------
    task check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task ahb_xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer
    task wr(input logic [7:0] a, input logic [15:0] d);
        ahb_xfer(a, 1'b1, d);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [15:0] e);
        ahb_xfer(a, 1'b0, 16'h0000);
        check(rd, {16'h0000, e});
    endtask : rd_chk
    task lock_chk(input logic e);
        ahb_xfer(OSC, 1'b0, 16'h0000);
        check({31'h0000_0000, rd[6]}, {31'h0000_0000, e});
    endtask : lock_chk
    task lock_seq(input logic [15:0] v);
        wr(OSC, 16'h0046);
        wr(OSC, 16'h0057);
        wr(OSC, v);
    endtask : lock_seq
    task tally_and_finish;
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Generous bound: the whole sequence needs about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        tally_and_finish;
    end

    // ----------------
    // Tests
    // ----------------
    initial
    begin
        {rst_n, haddr, htrans, hwrite, hwdata, cfg_n} = '0;
        periph = 64'h0000_0000_0000_0408;
        fails = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(M6, 16'h0000);
        rd_chk(M7, 16'h0000);
        lock_chk(1'b0);
        wr(M6, 16'hC5C3);
        wr(M7, 16'hCA09);
        rd_chk(M6, 16'h0503);
        rd_chk(M7, 16'h0A09);
        check({28'h000_0000, pin_out}, 32'h0000_0009);
        check({28'h000_0000, virt}, 32'h0000_0009);
        wr(IN0, 16'h0A03);
        rd_chk(IN0, 16'h0A03);
        check({20'h0_0000, insel[11:0]}, 32'h0000_0283);
        lock_seq(16'h0040);
        lock_chk(1'b1);
        wr(M6, 16'h0000);
        wr(IN0, 16'h0000);
        rd_chk(M6, 16'h0503);
        rd_chk(IN0, 16'h0A03);
        wr(OSC, 16'h0046);
        wr(EN, 16'h0000);
        wr(OSC, 16'h0057);
        wr(OSC, 16'h0000);
        lock_chk(1'b1);
        rd_chk(ST, 16'h0006);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        wr(EN, 16'h0006);
        rd_chk(EN, 16'h0006);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        wr(pin_remap_pkg::IRQ_CLR_OFF, 16'h0007);
        rd_chk(ST, 16'h0000);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        lock_seq(16'h0000);
        lock_chk(1'b0);
        wr(M6, 16'h0102);
        wr(M7, 16'h0304);
        rd_chk(M6, 16'h0102);
        rd_chk(M7, 16'h0304);
        rd_chk(8'h24, 16'h0000);
        cfg_n <= 1'b1;
        rd_chk(pin_remap_pkg::LOCK_CFG_OFF, 16'h0001);
        lock_seq(16'h0040);
        lock_seq(16'h0000);
        lock_chk(1'b1);
        wr(M6, 16'h0000);
        rd_chk(M6, 16'h0102);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        check({31'h0000_0000, mism}, 32'h0000_0000);
        check({31'h0000_0000, hresp}, 32'h0000_0000);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        lock_chk(1'b0);
        wr(M6, 16'h0011);
        rd_chk(M6, 16'h0011);
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
